// *** logic/mbx_pkg.sv ***
/*
  Shared constants for the interprocessor mailbox register block: register
  offsets, widths, reset values, status bit positions and the byte merge.
  Assumes byte addresses on a 32-bit Wishbone bus, one register per word.
*/
`default_nettype none
package mbx_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int WB_DW  = 32;
  localparam int WB_SEL = 4;
  localparam int N_D2H  = 2;
  localparam int N_STS  = 3;

  localparam logic [ADDR_W-1:0] OFF_H2D1_LO   = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_H2D1_HI   = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_D2H1_LO   = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_D2H1_HI   = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_D2H2_LO   = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_D2H2_HI   = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_FLAG_H2D1 = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_FLAG_D2H1 = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_FLAG_D2H2 = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STS   = 8'h30;
  localparam logic [ADDR_W-1:0] OFF_IRQ_CLR   = 8'h34;
  localparam logic [ADDR_W-1:0] OFF_IRQ_EN    = 8'h38;

  localparam logic [DATA_W-1:0] RST_WORD = 16'h0000;
  localparam logic [N_STS-1:0]  RST_STS  = 3'h0;
  localparam logic [N_STS-1:0]  RST_EN   = 3'h0;

  localparam int FLAG_INT_BIT = 0;
  localparam int STS_H2D1_TAKEN = 0;
  localparam int STS_D2H1_NEW   = 1;
  localparam int STS_D2H2_NEW   = 2;

  // byte lanes not selected keep their old contents
  function automatic logic [DATA_W-1:0] mergeWord(input logic [DATA_W-1:0] old,
                                                  input logic [DATA_W-1:0] wdat,
                                                  input logic [1:0]        sel);
    mergeWord = {sel[1] ? wdat[15:8] : old[15:8], sel[0] ? wdat[7:0] : old[7:0]};
  endfunction
endpackage
`default_nettype wire

// *** logic/mbx_acc_if.sv ***
/*
  Single-cycle register access between a Wishbone port and the mailbox core.
  Assumes the core answers rdat and err combinationally in the cycle of req.
*/
`timescale 1ns/1ps
`default_nettype none
interface mbx_acc_if;
  import mbx_pkg::*;
  logic              req;
  logic              we;
  logic [ADDR_W-1:0] addr;
  logic [1:0]        sel;
  logic [DATA_W-1:0] wdat;
  logic [DATA_W-1:0] rdat;
  logic              err;
  modport port (output req, we, addr, sel, wdat, input rdat, err);
  modport core (input req, we, addr, sel, wdat, output rdat, err);
endinterface
`default_nettype wire

// *** logic/mbx_wb_port.sv ***
/*
  Classic Wishbone slave that turns each bus cycle into one access pulse.
  Assumes a master that holds its request until ack or err is seen.
*/
`timescale 1ns/1ps
`default_nettype none
module mbx_wb_port (
  // clock and reset
  input  wire logic                        mclk,
  input  wire logic                        rst_n,
  // wishbone slave
  input  wire logic                        cyc,
  input  wire logic                        stb,
  input  wire logic                        we,
  input  wire logic [mbx_pkg::ADDR_W-1:0]  adr,
  input  wire logic [mbx_pkg::WB_SEL-1:0]  sel,
  input  wire logic [mbx_pkg::WB_DW-1:0]   datW,
  output logic      [mbx_pkg::WB_DW-1:0]   datR,
  output logic                             ack,
  output logic                             err,
  // access toward the core
  mbx_acc_if.port                          acc
);
  import mbx_pkg::*;

  logic             ack_ff;
  logic             err_ff;
  logic [WB_DW-1:0] datR_ff;

  // the answer flop masks req so a held request acts exactly once
  assign acc.req  = cyc & stb & ~ack_ff & ~err_ff;
  assign acc.we   = we;
  assign acc.addr = adr;
  assign acc.sel  = sel[1:0];
  assign acc.wdat = datW[DATA_W-1:0];

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ack_ff <= 1'b0;
      err_ff <= 1'b0;
    end else begin
      ack_ff <= acc.req & ~acc.err;
      err_ff <= acc.req & acc.err;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      datR_ff <= '0;
    end else if (acc.req & ~acc.we) begin
      datR_ff <= {{(WB_DW-DATA_W){1'b0}}, acc.rdat};
    end
  end

  assign ack  = ack_ff;
  assign err  = err_ff;
  assign datR = datR_ff;
endmodule
`default_nettype wire

// *** logic/mbx_regs.sv ***
/*
  Interprocessor mailbox registers: one host-to-DSP mailbox and two
  DSP-to-host mailboxes, each a low and a high 16-bit word with a pending
  flag, plus a host interrupt status, clear and enable set.
  Assumes two classic Wishbone masters on one clock: the host side (core,
  DMA engines, on-chip initiator port) tagged by hostIsCore, and the DSP core.
*/
// Decided for this implementation: the Wishbone register port.
// How it works
// - host-to-DSP low word, host read/write, DSP read only, resets to zero.
// - host write of host-to-DSP high word stores it, sets pending, raises irq.
// - DSP read of host-to-DSP high word clears pending and drops irq.
// - DSP-to-host low words, DSP read/write, host read only, reset zero.
// - DSP write of box-one high word stores, sets pending, raises host irq.
// - host core read of box-one high word clears its pending flag.
// - DSP write of box-two high word stores, sets pending, raises host irq.
// - host core read of box-two high word clears its pending flag.
// - low word writes never set pending nor raise an interrupt.
// - sender writes to a pending mailbox are dropped and answered with err.
// - sender reading its own high word keeps the pending flag.
// - flag registers only show pending; writes to them do nothing.
`timescale 1ns/1ps
`default_nettype none
module mbx_regs (
  // clock and reset
  input  wire logic                        mclk,
  input  wire logic                        rst_n,
  // host-side wishbone
  input  wire logic                        hostCyc,
  input  wire logic                        hostStb,
  input  wire logic                        hostWe,
  input  wire logic [mbx_pkg::ADDR_W-1:0]  hostAdr,
  input  wire logic [mbx_pkg::WB_SEL-1:0]  hostSel,
  input  wire logic [mbx_pkg::WB_DW-1:0]   hostDatW,
  input  wire logic                        hostIsCore,
  output logic      [mbx_pkg::WB_DW-1:0]   hostDatR,
  output logic                             hostAck,
  output logic                             hostErr,
  // dsp-side wishbone
  input  wire logic                        dspCyc,
  input  wire logic                        dspStb,
  input  wire logic                        dspWe,
  input  wire logic [mbx_pkg::ADDR_W-1:0]  dspAdr,
  input  wire logic [mbx_pkg::WB_SEL-1:0]  dspSel,
  input  wire logic [mbx_pkg::WB_DW-1:0]   dspDatW,
  output logic      [mbx_pkg::WB_DW-1:0]   dspDatR,
  output logic                             dspAck,
  output logic                             dspErr,
  // interrupts
  output logic                             h2dIrq,
  output logic                             d2h1Irq,
  output logic                             d2h2Irq,
  output logic                             hostIrq
);
  import mbx_pkg::*;

  localparam logic [ADDR_W-1:0] D2H_LO [N_D2H] = '{OFF_D2H1_LO, OFF_D2H2_LO};
  localparam logic [ADDR_W-1:0] D2H_HI [N_D2H] = '{OFF_D2H1_HI, OFF_D2H2_HI};
  localparam logic [ADDR_W-1:0] D2H_FL [N_D2H] = '{OFF_FLAG_D2H1, OFF_FLAG_D2H2};

  mbx_acc_if hAcc ();
  mbx_acc_if dAcc ();

  mbx_wb_port uHostPort (
    .mclk (mclk),
    .rst_n(rst_n),
    .cyc  (hostCyc),
    .stb  (hostStb),
    .we   (hostWe),
    .adr  (hostAdr),
    .sel  (hostSel),
    .datW (hostDatW),
    .datR (hostDatR),
    .ack  (hostAck),
    .err  (hostErr),
    .acc  (hAcc.port)
  );

  mbx_wb_port uDspPort (
    .mclk (mclk),
    .rst_n(rst_n),
    .cyc  (dspCyc),
    .stb  (dspStb),
    .we   (dspWe),
    .adr  (dspAdr),
    .sel  (dspSel),
    .datW (dspDatW),
    .datR (dspDatR),
    .ack  (dspAck),
    .err  (dspErr),
    .acc  (dAcc.port)
  );

  logic [DATA_W-1:0] h2dLo_ff;
  logic [DATA_W-1:0] h2dHi_ff;
  logic              h2dPend_ff;
  logic [DATA_W-1:0] d2hLo_ff [N_D2H];
  logic [DATA_W-1:0] d2hHi_ff [N_D2H];
  logic [N_D2H-1:0]  d2hPend_ff;
  logic [N_STS-1:0]  sts_ff;
  logic [N_STS-1:0]  en_ff;
  logic [N_STS-1:0]  nxt_sts;
  logic [N_STS-1:0]  stsSet;
  logic [N_STS-1:0]  stsClr;

  logic              hWr;
  logic              hRd;
  logic              dWr;
  logic              dRd;
  logic              hostLoWr;
  logic              hostHiWr;
  logic              dspHiRd;
  logic [N_D2H-1:0]  d2hLoWr;
  logic [N_D2H-1:0]  d2hHiWr;
  logic [N_D2H-1:0]  d2hHiRd;

  assign hWr = hAcc.req & hAcc.we;
  assign hRd = hAcc.req & ~hAcc.we;
  assign dWr = dAcc.req & dAcc.we;
  assign dRd = dAcc.req & ~dAcc.we;

  assign hostLoWr = hWr & (hAcc.addr == OFF_H2D1_LO) & ~h2dPend_ff;
  assign hostHiWr = hWr & (hAcc.addr == OFF_H2D1_HI) & ~h2dPend_ff;
  // only the receiving side's read releases the mailbox
  assign dspHiRd  = dRd & (dAcc.addr == OFF_H2D1_HI);

  always_comb begin
    for (int i = 0; i < N_D2H; i++) begin
      d2hLoWr[i] = dWr & (dAcc.addr == D2H_LO[i]) & ~d2hPend_ff[i];
      d2hHiWr[i] = dWr & (dAcc.addr == D2H_HI[i]) & ~d2hPend_ff[i];
      // DMA and initiator-port reads leave the flag alone
      d2hHiRd[i] = hRd & hostIsCore & (hAcc.addr == D2H_HI[i]);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      h2dLo_ff <= RST_WORD;
      h2dHi_ff <= RST_WORD;
    end else begin
      if (hostLoWr) h2dLo_ff <= mergeWord(h2dLo_ff, hAcc.wdat, hAcc.sel);
      if (hostHiWr) h2dHi_ff <= mergeWord(h2dHi_ff, hAcc.wdat, hAcc.sel);
    end
  end

  // set wins over a clear landing in the same cycle
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      h2dPend_ff <= 1'b0;
    end else if (hostHiWr) begin
      h2dPend_ff <= 1'b1;
    end else if (dspHiRd) begin
      h2dPend_ff <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    for (int i = 0; i < N_D2H; i++) begin
      if (!rst_n) begin
        d2hLo_ff[i] <= RST_WORD;
        d2hHi_ff[i] <= RST_WORD;
      end else begin
        if (d2hLoWr[i]) d2hLo_ff[i] <= mergeWord(d2hLo_ff[i], dAcc.wdat, dAcc.sel);
        if (d2hHiWr[i]) d2hHi_ff[i] <= mergeWord(d2hHi_ff[i], dAcc.wdat, dAcc.sel);
      end
    end
  end

  always_ff @(posedge mclk) begin
    for (int i = 0; i < N_D2H; i++) begin
      if (!rst_n) begin
        d2hPend_ff[i] <= 1'b0;
      end else if (d2hHiWr[i]) begin
        d2hPend_ff[i] <= 1'b1;
      end else if (d2hHiRd[i]) begin
        d2hPend_ff[i] <= 1'b0;
      end
    end
  end

  always_comb begin
    stsSet = '0;
    stsSet[STS_H2D1_TAKEN] = dspHiRd & h2dPend_ff & ~hostHiWr;
    stsSet[STS_D2H1_NEW]   = d2hHiWr[0];
    stsSet[STS_D2H2_NEW]   = d2hHiWr[1];
    stsClr  = (hWr && hAcc.addr == OFF_IRQ_CLR) ? hAcc.wdat[N_STS-1:0] : '0;
    nxt_sts = stsSet | (sts_ff & ~stsClr);
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sts_ff <= RST_STS;
    end else begin
      sts_ff <= nxt_sts;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      en_ff <= RST_EN;
    end else if (hWr && hAcc.addr == OFF_IRQ_EN) begin
      en_ff <= hAcc.wdat[N_STS-1:0];
    end
  end

  // the mailbox lines follow the flags, so masking elsewhere never loses one
  assign h2dIrq  = h2dPend_ff;
  assign d2h1Irq = d2hPendOut(0);
  assign d2h2Irq = d2hPendOut(1);
  assign hostIrq = |(sts_ff & en_ff);

  function automatic logic d2hPendOut(input int idx);
    d2hPendOut = d2hPend_ff[idx];
  endfunction

  // host port: host-to-DSP box is writable, DSP-to-host boxes read only
  always_comb begin
    hAcc.rdat = '0;
    hAcc.err  = 1'b0;
    case (hAcc.addr)
      OFF_H2D1_LO: begin
        hAcc.rdat = h2dLo_ff;
        hAcc.err  = hAcc.we & h2dPend_ff;
      end
      OFF_H2D1_HI: begin
        hAcc.rdat = h2dHi_ff;
        hAcc.err  = hAcc.we & h2dPend_ff;
      end
      OFF_D2H1_LO: begin
        hAcc.rdat = d2hLo_ff[0];
        hAcc.err  = hAcc.we;
      end
      OFF_D2H1_HI: begin
        hAcc.rdat = d2hHi_ff[0];
        hAcc.err  = hAcc.we;
      end
      OFF_D2H2_LO: begin
        hAcc.rdat = d2hLo_ff[1];
        hAcc.err  = hAcc.we;
      end
      OFF_D2H2_HI: begin
        hAcc.rdat = d2hHi_ff[1];
        hAcc.err  = hAcc.we;
      end
      OFF_FLAG_H2D1: hAcc.rdat[FLAG_INT_BIT] = h2dPend_ff;
      OFF_FLAG_D2H1: hAcc.rdat[FLAG_INT_BIT] = d2hPend_ff[0];
      OFF_FLAG_D2H2: hAcc.rdat[FLAG_INT_BIT] = d2hPend_ff[1];
      OFF_IRQ_STS:   hAcc.rdat = DATA_W'(sts_ff);
      OFF_IRQ_CLR:   hAcc.rdat = '0;
      OFF_IRQ_EN:    hAcc.rdat = DATA_W'(en_ff);
      default:       hAcc.err  = 1'b1;
    endcase
  end

  // dsp port: mirror image; status, clear and enable are host-only
  always_comb begin
    dAcc.rdat = '0;
    dAcc.err  = 1'b1;
    if (dAcc.addr == OFF_H2D1_LO) begin
      dAcc.rdat = h2dLo_ff;
      dAcc.err  = dAcc.we;
    end
    if (dAcc.addr == OFF_H2D1_HI) begin
      dAcc.rdat = h2dHi_ff;
      dAcc.err  = dAcc.we;
    end
    if (dAcc.addr == OFF_FLAG_H2D1) begin
      dAcc.rdat[FLAG_INT_BIT] = h2dPend_ff;
      dAcc.err  = 1'b0;
    end
    for (int i = 0; i < N_D2H; i++) begin
      if (dAcc.addr == D2H_LO[i]) begin
        dAcc.rdat = d2hLo_ff[i];
        dAcc.err  = dAcc.we & d2hPend_ff[i];
      end
      if (dAcc.addr == D2H_HI[i]) begin
        dAcc.rdat = d2hHi_ff[i];
        dAcc.err  = dAcc.we & d2hPend_ff[i];
      end
      if (dAcc.addr == D2H_FL[i]) begin
        dAcc.rdat[FLAG_INT_BIT] = d2hPend_ff[i];
        dAcc.err  = 1'b0;
      end
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  h2d_low_hold_a: assert property (!hostLoWr |=> $stable(h2dLo_ff))
    else $error("host-to-DSP low word changed without an accepted write");

  hi_write_pend_a: assert property (hostHiWr |=> h2dPend_ff && h2dIrq)
    else $error("high word write did not raise pending and irq");

  dsp_read_clr_a: assert property (dspHiRd && !hostHiWr |=> !h2dPend_ff && !h2dIrq)
    else $error("DSP read of high word left pending set");

  d2h_low_hold_a: assert property (!d2hLoWr[0] && !d2hLoWr[1] |=>
    $stable(d2hLo_ff[0]) && $stable(d2hLo_ff[1]))
    else $error("DSP-to-host low word changed without an accepted write");

  box1_set_a: assert property (d2hHiWr[0] |=> d2h1Irq && sts_ff[STS_D2H1_NEW])
    else $error("box one write did not raise host irq");

  box1_clr_a: assert property (d2hHiRd[0] && !d2hHiWr[0] |=> !d2h1Irq)
    else $error("host core read did not clear box one");

  box2_set_a: assert property (d2hHiWr[1] |=> d2h2Irq && sts_ff[STS_D2H2_NEW])
    else $error("box two write did not raise host irq");

  box2_clr_a: assert property (d2hHiRd[1] && !d2hHiWr[1] |=> !d2h2Irq)
    else $error("host core read did not clear box two");

  low_no_irq_a: assert property (hostLoWr |=> !h2dPend_ff)
    else $error("low word write set the pending flag");

  lock_err_a: assert property (hWr && h2dPend_ff &&
    (hAcc.addr == OFF_H2D1_LO || hAcc.addr == OFF_H2D1_HI) |=>
    hostErr && !hostAck && $stable(h2dLo_ff) && $stable(h2dHi_ff))
    else $error("write to locked mailbox was not refused");

  self_read_a: assert property (hRd && h2dPend_ff &&
    hAcc.addr == OFF_H2D1_HI && !dspHiRd |=> h2dPend_ff)
    else $error("sender read cleared its own pending flag");

  flag_write_a: assert property (hWr && hAcc.addr == OFF_FLAG_H2D1 && !dspHiRd |=>
    hostAck && $stable(h2dPend_ff))
    else $error("flag register write had an effect");
endmodule
`default_nettype wire

// *** testbench/mbx_wb_master.sv ***
/*
  Behavioural classic Wishbone master standing in for one processor side
  (host initiators or the DSP core) in front of the mailbox registers.
  Assumes one clock; the testbench calls xfer to run one bus cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module mbx_wb_master (
  // clock
  input  wire logic                       mclk,
  // wishbone master
  output logic                            cyc,
  output logic                            stb,
  output logic                            we,
  output logic [mbx_pkg::ADDR_W-1:0]      adr,
  output logic [mbx_pkg::WB_SEL-1:0]      sel,
  output logic [mbx_pkg::WB_DW-1:0]       datW,
  output logic                            isCore,
  input  wire logic [mbx_pkg::WB_DW-1:0]  datR,
  input  wire logic                       ack,
  input  wire logic                       err
);
  import mbx_pkg::*;
  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'hF;
    datW = 32'h0;
    isCore = 1'b0;
  end
  // holds the request until the answer edge; the answer is waited for, never assumed
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [WB_DW-1:0] d,
                      input logic [WB_SEL-1:0] s, input logic core,
                      output logic [WB_DW-1:0] r, output logic e);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    datW <= d;
    isCore <= core;
    // no cycle limit here: a slave that never answers is caught by the bench watchdog
    do begin
      @(posedge mclk);
    end while (!(ack === 1'b1 || err === 1'b1));
    r = datR;
    e = (err === 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    // released lines show the inverse so a stale value is never mistaken for live
    we <= ~w;
    adr <= ~a;
    sel <= ~s;
    datW <= ~d;
    isCore <= ~core;
  endtask
endmodule
`default_nettype wire

// *** testbench/test_interprocessor_mailbox_regs.sv ***
/*
  Self-checking bench for the mailbox registers: two partner masters, random
  data from a fixed seed, expectations kept in the bench.
  Assumes mbx_regs and mbx_pkg as delivered; one 200 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module test_interprocessor_mailbox_regs;
  import mbx_pkg::*;
  logic mclk, rst_n;
  logic hostCyc, hostStb, hostWe, hostIsCore, hostAck, hostErr;
  logic [ADDR_W-1:0] hostAdr, dspAdr;
  logic [WB_SEL-1:0] hostSel, dspSel;
  logic [WB_DW-1:0]  hostDatW, hostDatR, dspDatW, dspDatR, rd;
  logic dspCyc, dspStb, dspWe, dspAck, dspErr, h2dIrq, d2h1Irq, d2h2Irq, hostIrq, e;
  logic [DATA_W-1:0] lo, hi;
  logic [ADDR_W-1:0] base;
  logic [WB_SEL-1:0] bSel;
  int failures, checks, seed, i, k;

  mbx_regs i_dut (.mclk(mclk), .rst_n(rst_n), .hostCyc(hostCyc), .hostStb(hostStb),
    .hostWe(hostWe), .hostAdr(hostAdr), .hostSel(hostSel), .hostDatW(hostDatW),
    .hostIsCore(hostIsCore), .hostDatR(hostDatR), .hostAck(hostAck), .hostErr(hostErr),
    .dspCyc(dspCyc), .dspStb(dspStb), .dspWe(dspWe), .dspAdr(dspAdr), .dspSel(dspSel),
    .dspDatW(dspDatW), .dspDatR(dspDatR), .dspAck(dspAck), .dspErr(dspErr),
    .h2dIrq(h2dIrq), .d2h1Irq(d2h1Irq), .d2h2Irq(d2h2Irq), .hostIrq(hostIrq));
  mbx_wb_master i_hostM (.mclk(mclk), .cyc(hostCyc), .stb(hostStb), .we(hostWe),
    .adr(hostAdr), .sel(hostSel), .datW(hostDatW), .isCore(hostIsCore),
    .datR(hostDatR), .ack(hostAck), .err(hostErr));
  mbx_wb_master i_dspM (.mclk(mclk), .cyc(dspCyc), .stb(dspStb), .we(dspWe),
    .adr(dspAdr), .sel(dspSel), .datW(dspDatW), .isCore(),
    .datR(dspDatR), .ack(dspAck), .err(dspErr));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic chkW(input logic [WB_DW-1:0] got, input logic [WB_DW-1:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkB(input logic got, input logic exp);
    chkW({31'h0, got}, {31'h0, exp});
  endtask
  // one host access; a read expected without err is compared against exp
  task automatic host(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                      input logic core, input logic eErr, input logic [DATA_W-1:0] exp);
    i_hostM.xfer(w, a, {16'h0000, d}, bSel, core, rd, e);
    chkB(e, eErr);
    if (!w && !eErr) chkW(rd, {16'h0000, exp});
  endtask
  task automatic dsp(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                     input logic eErr, input logic [DATA_W-1:0] exp);
    i_dspM.xfer(w, a, {16'h0000, d}, bSel, 1'b0, rd, e);
    chkB(e, eErr);
    if (!w && !eErr) chkW(rd, {16'h0000, exp});
  endtask
  function automatic logic boxIrq(input int b);
    boxIrq = (b == 0) ? d2h1Irq : d2h2Irq;
  endfunction
  // byte lanes: sel bit 0 writes bits 7:0, sel bit 1 writes bits 15:8
  function automatic logic [DATA_W-1:0] mergeExp(input logic [DATA_W-1:0] o,
                                                 input logic [DATA_W-1:0] n,
                                                 input logic [1:0]        s);
    mergeExp = {s[1] ? n[15:8] : o[15:8], s[0] ? n[7:0] : o[7:0]};
  endfunction
  task automatic stop_test();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    stop_test();
  end

  initial begin
    failures = 0;
    checks = 0;
    seed = 68231;
    bSel = 4'hF;
    rst_n = 1'b0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    for (i = 0; i < 9; i++) host(1'b0, 8'(i * 4), 16'h0, 1'b1, 1'b0, RST_WORD);
    host(1'b0, OFF_IRQ_STS, 16'h0, 1'b1, 1'b0, 16'h0000);
    host(1'b0, 8'h40, 16'h0, 1'b1, 1'b1, 16'h0000);
    dsp(1'b0, 8'h02, 16'h0, 1'b1, 16'h0000);
    $display("test reset_and_decode done");
    for (k = 0; k < 3; k++) begin
      lo = 16'($random(seed));
      hi = 16'($random(seed));
      dsp(1'b1, OFF_H2D1_LO, lo, 1'b1, 16'h0);
      host(1'b1, OFF_H2D1_LO, lo, 1'($random(seed)), 1'b0, 16'h0);
      chkB(h2dIrq, 1'b0);
      host(1'b1, OFF_H2D1_HI, hi, 1'($random(seed)), 1'b0, 16'h0);
      chkB(h2dIrq, 1'b1);
      host(1'b1, OFF_H2D1_LO, ~lo, 1'b1, 1'b1, 16'h0);
      host(1'b0, OFF_H2D1_HI, 16'h0, 1'b1, 1'b0, hi);
      host(1'b1, OFF_FLAG_H2D1, 16'h0, 1'b1, 1'b0, 16'h0);
      dsp(1'b0, OFF_FLAG_H2D1, 16'h0, 1'b0, 16'h0001);
      dsp(1'b0, OFF_H2D1_LO, 16'h0, 1'b0, lo);
      dsp(1'b0, OFF_H2D1_HI, 16'h0, 1'b0, hi);
      chkB(h2dIrq, 1'b0);
      dsp(1'b0, OFF_FLAG_H2D1, 16'h0, 1'b0, 16'h0000);
    end
    $display("test host_to_dsp done");
    for (k = 0; k < 2; k++) begin
      base = 8'(8 + k * 8);
      lo = 16'($random(seed));
      hi = 16'($random(seed));
      dsp(1'b1, base, lo, 1'b0, 16'h0);
      chkB(boxIrq(k), 1'b0);
      host(1'b1, base, ~lo, 1'b1, 1'b1, 16'h0);
      dsp(1'b1, base + 8'h04, hi, 1'b0, 16'h0);
      chkB(boxIrq(k), 1'b1);
      dsp(1'b1, base, ~lo, 1'b1, 16'h0);
      dsp(1'b0, base + 8'h04, 16'h0, 1'b0, hi);
      host(1'b0, base, 16'h0, 1'($random(seed)), 1'b0, lo);
      host(1'b0, base + 8'h04, 16'h0, 1'b0, 1'b0, hi);
      chkB(boxIrq(k), 1'b1);
      host(1'b0, base + 8'h04, 16'h0, 1'b1, 1'b0, hi);
      chkB(boxIrq(k), 1'b0);
    end
    $display("test dsp_to_host done");
    host(1'b0, OFF_IRQ_STS, 16'h0, 1'b1, 1'b0, 16'h0007);
    chkB(hostIrq, 1'b0);
    host(1'b1, OFF_IRQ_EN, 16'h0002, 1'b1, 1'b0, 16'h0);
    host(1'b0, OFF_IRQ_EN, 16'h0, 1'b1, 1'b0, 16'h0002);
    chkB(hostIrq, 1'b1);
    dsp(1'b1, OFF_IRQ_CLR, 16'h0002, 1'b1, 16'h0);
    host(1'b1, OFF_IRQ_CLR, 16'h0002, 1'b1, 1'b0, 16'h0);
    chkB(hostIrq, 1'b0);
    host(1'b0, OFF_IRQ_STS, 16'h0, 1'b1, 1'b0, 16'h0005);
    host(1'b1, OFF_IRQ_CLR, 16'h0005, 1'b1, 1'b0, 16'h0);
    host(1'b0, OFF_IRQ_STS, 16'h0, 1'b1, 1'b0, 16'h0000);
    $display("test interrupts done");
    lo = 16'($random(seed));
    hi = 16'($random(seed));
    host(1'b1, OFF_H2D1_LO, lo, 1'b1, 1'b0, 16'h0);
    bSel = 4'h2;
    host(1'b1, OFF_H2D1_LO, hi, 1'b1, 1'b0, 16'h0);
    bSel = 4'h0;
    host(1'b1, OFF_H2D1_HI, hi, 1'b1, 1'b0, 16'h0);
    bSel = 4'hF;
    dsp(1'b0, OFF_H2D1_LO, 16'h0, 1'b0, mergeExp(lo, hi, 2'b10));
    chkB(h2dIrq, 1'b1);
    dsp(1'b1, OFF_D2H1_HI, hi, 1'b0, 16'h0);
    chkB(hostIrq, 1'b1);
    // second reset in mid-run with mailboxes pending and the irq enabled
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    chkB(h2dIrq, 1'b0);
    chkB(d2h1Irq, 1'b0);
    chkB(hostIrq, 1'b0);
    host(1'b0, OFF_H2D1_LO, 16'h0, 1'b1, 1'b0, RST_WORD);
    host(1'b0, OFF_D2H1_HI, 16'h0, 1'b1, 1'b0, RST_WORD);
    host(1'b0, OFF_IRQ_EN, 16'h0, 1'b1, 1'b0, 16'h0000);
    $display("test lanes_and_reset done");
    stop_test();
  end
endmodule
`default_nettype wire
